// >>> core/clock_control_pkg.sv
// shared constants, encodings and carriers of the clock control block
package clock_control_pkg;

	// register bus geometry
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;

	// register offsets, clock group
	localparam logic [7:0] SYS_CLOCK_SELECT_OFFSET       = 8'h00;
	localparam logic [7:0] PRESCALER_REGISTER_OFFSET     = 8'h01;
	localparam logic [7:0] CLOCK_CONFIG_FREEZE_OFFSET    = 8'h02;
	localparam logic [7:0] RTC_CLOCK_SELECT_OFFSET       = 8'h03;
	localparam logic [7:0] PROTECT_KEY_OFFSET            = 8'h08;
	// register offsets, oscillator group
	localparam logic [7:0] OSCILLATOR_ENABLES_OFFSET     = 8'h10;
	localparam logic [7:0] OSCILLATOR_READY_FLAGS_OFFSET = 8'h11;
	localparam logic [7:0] CRYSTAL_OSC_CONFIG_OFFSET     = 8'h12;

	// writable bits per register (the ready mask marks read-only status bits), everything else is reserved
	localparam logic [7:0] SYS_CLOCK_SELECT_MASK    = 8'h07;
	localparam logic [7:0] PRESCALER_REGISTER_MASK  = 8'h7F;
	localparam logic [7:0] CLOCK_CONFIG_FREEZE_MASK = 8'h01;
	localparam logic [7:0] RTC_CLOCK_SELECT_MASK    = 8'h0F;
	localparam logic [7:0] OSCILLATOR_ENABLES_MASK  = 8'h1F;
	localparam logic [7:0] OSCILLATOR_READY_MASK    = 8'h1F;
	localparam logic [7:0] CRYSTAL_OSC_CONFIG_MASK  = 8'hEF;

	// values after reset
	localparam logic [7:0] OSCILLATOR_ENABLES_RESET = 8'h01;
	localparam logic [7:0] CONFIG_RESET             = 8'h00;

	// field positions
	localparam int unsigned FREEZE_BIT         = 0;
	localparam int unsigned RTC_ENABLE_BIT     = 0;
	localparam int unsigned RTC_SOURCE_LSB     = 1;
	localparam int unsigned STAGE_BC_LSB       = 0;
	localparam int unsigned PRESCALE_A_LSB     = 2;
	localparam int unsigned CRYSTAL_RANGE_LSB  = 6;
	localparam int unsigned CRYSTAL_LOWPWR_BIT = 5;
	localparam int unsigned CRYSTAL_TYPE_LSB   = 0;
	localparam int unsigned SOURCE_COUNT       = 5;

	// timed-write protection; key value is arbitrary
	localparam logic [7:0] PROTECT_KEY_VALUE     = 8'h5A;
	localparam logic [2:0] PROTECT_WINDOW_CYCLES = 3'h4;
	// cycles a source must report stable before its ready flag rises
	localparam logic [2:0] READY_FILTER_CYCLES   = 3'h4;

	// real-time counter source codes
	typedef enum logic [2:0]
	{
		RTC_LOW_POWER_1K     = 3'h0,
		RTC_WATCH_CRYSTAL_1K = 3'h1,
		RTC_INTERNAL_1K      = 3'h2,
		RTC_WATCH_CRYSTAL_32K = 3'h5
	} rtc_source_t;

	// prescaler B and C division codes
	typedef enum logic [1:0]
	{
		BC_NO_DIVIDE   = 2'h0,
		BC_C_HALVES    = 2'h1,
		BC_B_QUARTERS  = 2'h2,
		BC_BOTH_HALVE  = 2'h3
	} stage_bc_divide_t;

	// one-hot clock route to the real-time counter
	typedef struct packed
	{
		logic low_power_oscillator_1k;
		logic watch_crystal_pins_1k;
		logic internal_oscillator_1k;
		logic watch_crystal_pins_32k;
	} rtc_route_t;

	// crystal oscillator settings to the analog side
	typedef struct packed
	{
		logic [1:0] crystal_range_select;
		logic       low_power_swing;
		logic [3:0] crystal_type_select;
	} crystal_setting_t;

endpackage

// >>> core/stage_bc_prescaler.sv
// prescaler B and C as clock-enable strobes derived from the quad rate
`timescale 1ns/1ps
module stage_bc_prescaler
(
	input  wire logic                        mclk,
	input  wire logic                        reset,
	input  wire logic                        clk_en,
	input  wire logic                        quad_rate_tick,
	input  wire logic [1:0]                  stage_bc_divide_select,
	output logic                             double_rate_tick,
	output logic                             cpu_tick
);
	import clock_control_pkg::*;

	logic [1:0] b_count;
	logic [1:0] next_b_count;
	logic       c_count;
	logic       next_c_count;
	logic       next_double_rate_tick;
	logic       next_cpu_tick;
	logic [1:0] b_last;
	logic       c_divides;
	logic       b_out;

	// decode the divide code into stage lengths
	always_comb
	begin
		b_last    = 2'h0;
		c_divides = 1'b0;
		case (stage_bc_divide_t'(stage_bc_divide_select))
			BC_NO_DIVIDE:  begin b_last = 2'h0; c_divides = 1'b0; end
			BC_C_HALVES:   begin b_last = 2'h0; c_divides = 1'b1; end
			BC_B_QUARTERS: begin b_last = 2'h3; c_divides = 1'b0; end
			BC_BOTH_HALVE: begin b_last = 2'h1; c_divides = 1'b1; end
			default:       begin b_last = 2'h0; c_divides = 1'b0; end
		endcase
		// stage C only counts what stage B lets through
		b_out = quad_rate_tick && (b_count >= b_last);
		next_b_count = b_count;
		next_c_count = c_count;
		if (quad_rate_tick)
			next_b_count = b_out ? 2'h0 : b_count + 2'h1;
		if (b_out)
			next_c_count = c_divides ? ~c_count : 1'b0;
		next_double_rate_tick = b_out;
		next_cpu_tick = b_out && (!c_divides || c_count);
	end

	// register counters and strobes
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			b_count          <= 2'h0;
			c_count          <= 1'b0;
			double_rate_tick <= 1'b0;
			cpu_tick         <= 1'b0;
		end
		else if (clk_en)
		begin
			b_count          <= next_b_count;
			c_count          <= next_c_count;
			double_rate_tick <= next_double_rate_tick;
			cpu_tick         <= next_cpu_tick;
		end
	end

	property p_bc_pass_through;
		@(posedge mclk) disable iff (reset)
		(clk_en && quad_rate_tick && stage_bc_divide_select == 2'h0)
			|=> (double_rate_tick && cpu_tick);
	endproperty
	a_bc_pass_through: assert property (p_bc_pass_through)
		else $error("undivided setting lost a tick");

endmodule

// >>> core/clock_source_prescale_control.sv
// clock source enables, ready flags, prescaler, lock and rtc routing
//
// Overview of operation
// - B/C code: 00 none, 01 C/2, 10 B/4, 11 both/2
// - B divides quad rate, C divides B output
// - lock set freezes clock select and prescaler writes
// - lock bit written only through timed protected write
// - lock clears only by reset, zero write ignored
// - rtc source code picks one of four clocks
// - rtc clock gated off unless rtc enable set
// - bits 4..0 enable pll, external, slow, fast, default
// - reset leaves only default oscillator enabled
// - pll ready flag set once pll locked
// - external ready flag set once source stable
// - separate ready flags for three internal oscillators
// - two-bit crystal frequency range field
// - reserved bits read zero, writes masked
// - prescaler written only through timed protected write
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module clock_source_prescale_control
(
	input  wire logic                                  mclk,
	input  wire logic                                  reset,
	input  wire logic                                  clk_en,
	input  wire logic [clock_control_pkg::ADDR_W-1:0]  reg_addr,
	input  wire logic [clock_control_pkg::DATA_W-1:0]  reg_wdata,
	input  wire logic                                  reg_wr,
	input  wire logic                                  reg_rd,
	output logic [clock_control_pkg::DATA_W-1:0]       reg_rdata,
	input  wire logic [4:0]                            osc_stable,
	input  wire logic                                  quad_rate_tick,
	output logic [4:0]                                 osc_enable,
	output logic [2:0]                                 sys_clock_select,
	output logic [4:0]                                 prescale_a_select,
	output logic                                       double_rate_tick,
	output logic                                       cpu_tick,
	output clock_control_pkg::rtc_route_t              rtc_route,
	output clock_control_pkg::crystal_setting_t        crystal_setting,
	output logic                                       clock_config_frozen
);
	import clock_control_pkg::*;

	typedef enum logic {PROT_CLOSED, PROT_OPEN} protect_state_t;

	protect_state_t protect_state;
	protect_state_t next_protect_state;
	logic [2:0]     protect_count;
	logic [2:0]     next_protect_count;
	logic           lock;
	logic           next_lock;
	logic [7:0]     sys_select_reg;
	logic [7:0]     next_sys_select_reg;
	logic [7:0]     prescaler_register;
	logic [7:0]     next_prescaler_register;
	logic [7:0]     rtc_clock_select;
	logic [7:0]     next_rtc_clock_select;
	logic [7:0]     oscillator_enables;
	logic [7:0]     next_oscillator_enables;
	logic [7:0]     crystal_osc_config;
	logic [7:0]     next_crystal_osc_config;
	logic [4:0]     ready_flags;
	logic [4:0]     next_ready_flags;
	logic [7:0]     next_reg_rdata;
	rtc_route_t     next_rtc_route;
	logic           window_open;
	logic           protected_hit;
	logic [2:0]     rtc_code;

	assign window_open = (protect_state == PROT_OPEN);
	assign rtc_code    = rtc_clock_select[RTC_SOURCE_LSB +: 3];

	// protected registers: any write to them spends the open window
	always_comb
	begin
		protected_hit = reg_wr &&
			(reg_addr == SYS_CLOCK_SELECT_OFFSET ||
			 reg_addr == PRESCALER_REGISTER_OFFSET ||
			 reg_addr == CLOCK_CONFIG_FREEZE_OFFSET);
		next_protect_state = protect_state;
		next_protect_count = protect_count;
		if (reg_wr && reg_addr == PROTECT_KEY_OFFSET &&
			reg_wdata == PROTECT_KEY_VALUE)
		begin
			next_protect_state = PROT_OPEN;
			next_protect_count = PROTECT_WINDOW_CYCLES;
		end
		else
		begin
			case (protect_state)
				PROT_CLOSED:
					next_protect_count = 3'h0;
				PROT_OPEN:
				begin
					// window is short so stray code rarely hits it
					if (protected_hit || protect_count == 3'h1)
					begin
						next_protect_state = PROT_CLOSED;
						next_protect_count = 3'h0;
					end
					else
						next_protect_count = protect_count - 3'h1;
				end
				default:
				begin
					next_protect_state = PROT_CLOSED;
					next_protect_count = 3'h0;
				end
			endcase
		end
	end

	// software-written configuration, masked so reserved bits stay zero
	always_comb
	begin
		next_lock               = lock;
		next_sys_select_reg     = sys_select_reg;
		next_prescaler_register = prescaler_register;
		next_rtc_clock_select   = rtc_clock_select;
		next_oscillator_enables = oscillator_enables;
		next_crystal_osc_config = crystal_osc_config;
		if (reg_wr)
		begin
			case (reg_addr)
				SYS_CLOCK_SELECT_OFFSET:
					if (window_open && !lock)
						next_sys_select_reg =
							reg_wdata & SYS_CLOCK_SELECT_MASK;
				PRESCALER_REGISTER_OFFSET:
					if (window_open && !lock)
						next_prescaler_register =
							reg_wdata & PRESCALER_REGISTER_MASK;
				CLOCK_CONFIG_FREEZE_OFFSET:
					// only a one sticks; zero never clears it
					if (window_open && reg_wdata[FREEZE_BIT])
						next_lock = 1'b1;
				RTC_CLOCK_SELECT_OFFSET:
					next_rtc_clock_select =
						reg_wdata & RTC_CLOCK_SELECT_MASK;
				OSCILLATOR_ENABLES_OFFSET:
					next_oscillator_enables =
						reg_wdata & OSCILLATOR_ENABLES_MASK;
				CRYSTAL_OSC_CONFIG_OFFSET:
					next_crystal_osc_config =
						reg_wdata & CRYSTAL_OSC_CONFIG_MASK;
				default:
					next_lock = lock; // status and unmapped: no effect
			endcase
		end
	end

	// configuration and protection registers
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			protect_state      <= PROT_CLOSED;
			protect_count      <= 3'h0;
			lock               <= 1'b0;
			sys_select_reg     <= CONFIG_RESET;
			prescaler_register <= CONFIG_RESET;
			rtc_clock_select   <= CONFIG_RESET;
			oscillator_enables <= OSCILLATOR_ENABLES_RESET;
			crystal_osc_config <= CONFIG_RESET;
		end
		else if (clk_en)
		begin
			protect_state      <= next_protect_state;
			protect_count      <= next_protect_count;
			lock               <= next_lock;
			sys_select_reg     <= next_sys_select_reg;
			prescaler_register <= next_prescaler_register;
			rtc_clock_select   <= next_rtc_clock_select;
			oscillator_enables <= next_oscillator_enables;
			crystal_osc_config <= next_crystal_osc_config;
		end
	end

	// per-source ready qualification; a glitchy stable input restarts it
	genvar i;
	generate
		for (i = 0; i < SOURCE_COUNT; i++)
		begin : g_ready
			logic [2:0] settle;
			logic [2:0] next_settle;

			always_comb
			begin
				next_settle = settle;
				next_ready_flags[i] = ready_flags[i];
				if (!oscillator_enables[i] || !osc_stable[i])
				begin
					next_settle = 3'h0;
					next_ready_flags[i] = 1'b0;
				end
				else if (settle == READY_FILTER_CYCLES - 3'h1)
					next_ready_flags[i] = 1'b1;
				else
					next_settle = settle + 3'h1;
			end

			always_ff @(posedge mclk)
			begin
				if (reset)
				begin
					settle         <= 3'h0;
					ready_flags[i] <= 1'b0;
				end
				else if (clk_en)
				begin
					settle         <= next_settle;
					ready_flags[i] <= next_ready_flags[i];
				end
			end
		end
	endgenerate

	// read mux and rtc route; reserved and unmapped read as zero
	always_comb
	begin
		next_reg_rdata = 8'h00;
		if (reg_rd)
		begin
			case (reg_addr)
				SYS_CLOCK_SELECT_OFFSET:    next_reg_rdata = sys_select_reg;
				PRESCALER_REGISTER_OFFSET:  next_reg_rdata = prescaler_register;
				CLOCK_CONFIG_FREEZE_OFFSET: next_reg_rdata = {7'h00, lock};
				RTC_CLOCK_SELECT_OFFSET:    next_reg_rdata = rtc_clock_select;
				OSCILLATOR_ENABLES_OFFSET:  next_reg_rdata = oscillator_enables;
				OSCILLATOR_READY_FLAGS_OFFSET:
					next_reg_rdata = {3'h0, ready_flags};
				CRYSTAL_OSC_CONFIG_OFFSET:  next_reg_rdata = crystal_osc_config;
				default:                    next_reg_rdata = 8'h00;
			endcase
		end
		next_rtc_route = '0;
		if (rtc_clock_select[RTC_ENABLE_BIT])
		begin
			case (rtc_source_t'(rtc_code))
				RTC_LOW_POWER_1K:
					next_rtc_route.low_power_oscillator_1k = 1'b1;
				RTC_WATCH_CRYSTAL_1K:
					next_rtc_route.watch_crystal_pins_1k = 1'b1;
				RTC_INTERNAL_1K:
					next_rtc_route.internal_oscillator_1k = 1'b1;
				RTC_WATCH_CRYSTAL_32K:
					next_rtc_route.watch_crystal_pins_32k = 1'b1;
				default:
					next_rtc_route = '0; // reserved codes deliver nothing
			endcase
		end
	end

	// output flops
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			reg_rdata <= 8'h00;
			rtc_route <= '0;
		end
		else if (clk_en)
		begin
			reg_rdata <= next_reg_rdata;
			rtc_route <= next_rtc_route;
		end
	end

	// these are the configuration flops themselves
	assign osc_enable          = oscillator_enables[4:0];
	assign sys_clock_select    = sys_select_reg[2:0];
	assign prescale_a_select   = prescaler_register[PRESCALE_A_LSB +: 5];
	assign clock_config_frozen = lock;
	assign crystal_setting     = {crystal_osc_config[CRYSTAL_RANGE_LSB +: 2],
		crystal_osc_config[CRYSTAL_LOWPWR_BIT],
		crystal_osc_config[CRYSTAL_TYPE_LSB +: 4]};

	stage_bc_prescaler i_stage_bc_prescaler
	(
		.mclk                   (mclk),
		.reset                  (reset),
		.clk_en                 (clk_en),
		.quad_rate_tick         (quad_rate_tick),
		.stage_bc_divide_select (prescaler_register[STAGE_BC_LSB +: 2]),
		.double_rate_tick       (double_rate_tick),
		.cpu_tick               (cpu_tick)
	);

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	sequence s_key_write;
		clk_en && reg_wr && reg_addr == PROTECT_KEY_OFFSET &&
			reg_wdata == PROTECT_KEY_VALUE;
	endsequence
	sequence s_freeze_write;
		clk_en && reg_wr && reg_addr == CLOCK_CONFIG_FREEZE_OFFSET &&
			reg_wdata[0];
	endsequence

	property p_lock_via_key;
		s_key_write ##1 !reg_wr ##1 s_freeze_write |=> lock;
	endproperty
	a_lock_via_key: assert property (p_lock_via_key)
		else $error("protected freeze write did not lock");

	property p_lock_needs_window;
		$rose(lock) |-> $past(window_open) && $past(reg_wr);
	endproperty
	a_lock_needs_window: assert property (p_lock_needs_window)
		else $error("lock set without protected write");

	property p_lock_sticky;
		lock |=> lock;
	endproperty
	a_lock_sticky: assert property (p_lock_sticky)
		else $error("lock cleared without reset");

	property p_locked_prescaler_hold;
		(lock && reg_wr && reg_addr == PRESCALER_REGISTER_OFFSET)
			|=> $stable(prescaler_register) && $stable(sys_select_reg);
	endproperty
	a_locked_prescaler_hold: assert property (p_locked_prescaler_hold)
		else $error("locked prescaler changed");

	property p_unprotected_ignored;
		(!window_open && reg_wr && reg_addr == PRESCALER_REGISTER_OFFSET)
			|=> $stable(prescaler_register);
	endproperty
	a_unprotected_ignored: assert property (p_unprotected_ignored)
		else $error("unprotected prescaler write took effect");

	property p_enable_reset;
		$fell(reset) |-> osc_enable == 5'h01;
	endproperty
	a_enable_reset: assert property (p_enable_reset)
		else $error("oscillator enables wrong after reset");

	property p_ready_needs_enable;
		(ready_flags & ~$past(osc_enable)) == 5'h00;
	endproperty
	a_ready_needs_enable: assert property (p_ready_needs_enable)
		else $error("ready flag set for disabled source");

	property p_rtc_gated;
		(clk_en && !rtc_clock_select[RTC_ENABLE_BIT]) |=> rtc_route == '0;
	endproperty
	a_rtc_gated: assert property (p_rtc_gated)
		else $error("rtc clock delivered while disabled");

	property p_status_reserved_zero;
		(clk_en && reg_rd && reg_addr == OSCILLATOR_READY_FLAGS_OFFSET)
			|=> reg_rdata[7:5] == 3'h0;
	endproperty
	a_status_reserved_zero: assert property (p_status_reserved_zero)
		else $error("reserved status bits read nonzero");

endmodule

// >>> bench/osc_source_model.sv
// behavioural oscillators, pll lock and quad-rate tick source
`timescale 1ns/1ps
module osc_source_model
#(
	parameter int DELAY_PLL = 30,
	parameter int DELAY_EXT = 12,
	parameter int DELAY_32K = 20,
	parameter int DELAY_32M = 5,
	parameter int DELAY_2M  = 2
)
(
	input  wire logic       mclk,
	input  wire logic       reset,
	input  wire logic [4:0] osc_enable,
	output logic [4:0]      osc_stable,
	output logic            quad_rate_tick
);
	int count [5];

	// start-up time of each source, slow ones exercise the ready filter
	function automatic int settle_of(input int i);
		case (i)
			4: return DELAY_PLL;
			3: return DELAY_EXT;
			2: return DELAY_32K;
			1: return DELAY_32M;
			default: return DELAY_2M;
		endcase
	endfunction

	// a source counts towards stable only while enabled; off drops it at once
	always_ff @(posedge mclk)
	begin
		for (int i = 0; i < 5; i++)
		begin
			if (reset || !osc_enable[i])
				count[i] <= 0;
			else if (count[i] < settle_of(i))
				count[i] <= count[i] + 1;
		end
		quad_rate_tick <= !reset && !quad_rate_tick; // tick every 2nd cycle
	end

	// stable only while enabled and settled
	always_comb
	begin
		for (int i = 0; i < 5; i++)
			osc_stable[i] = osc_enable[i] && (count[i] == settle_of(i));
	end
endmodule

// >>> bench/clock_source_prescale_control_bench.sv
// self-checking bench for the clock source and prescaler control block
`timescale 1ns/1ps
module clock_source_prescale_control_bench;
	import clock_control_pkg::*;

	logic              mclk;
	logic              reset;
	logic              clk_en;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata;
	logic              reg_wr;
	logic              reg_rd;
	logic [DATA_W-1:0] reg_rdata;
	logic [4:0]        osc_stable;
	logic              quad_rate_tick;
	logic [4:0]        osc_enable;
	logic [2:0]        sys_clock_select;
	logic [4:0]        prescale_a_select;
	logic              double_rate_tick;
	logic              cpu_tick;
	rtc_route_t        rtc_route;
	crystal_setting_t  crystal_setting;
	logic              clock_config_frozen;
	int                miscompares;
	int                comparisons;
	int                cycles;
	logic [7:0]        rd_val;

	clock_source_prescale_control i_clock_source_prescale_control
	(
		.mclk                (mclk),
		.reset               (reset),
		.clk_en              (clk_en),
		.reg_addr            (reg_addr),
		.reg_wdata           (reg_wdata),
		.reg_wr              (reg_wr),
		.reg_rd              (reg_rd),
		.reg_rdata           (reg_rdata),
		.osc_stable          (osc_stable),
		.quad_rate_tick      (quad_rate_tick),
		.osc_enable          (osc_enable),
		.sys_clock_select    (sys_clock_select),
		.prescale_a_select   (prescale_a_select),
		.double_rate_tick    (double_rate_tick),
		.cpu_tick            (cpu_tick),
		.rtc_route           (rtc_route),
		.crystal_setting     (crystal_setting),
		.clock_config_frozen (clock_config_frozen)
	);

	osc_source_model i_osc_source_model
	(
		.mclk           (mclk),
		.reset          (reset),
		.osc_enable     (osc_enable),
		.osc_stable     (osc_stable),
		.quad_rate_tick (quad_rate_tick)
	);

	// 250 MHz clock
	always #2 mclk = ~mclk;

	// hang guard, the whole sequence needs well under 3000 cycles
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			stop_test();
		end
	end

	task automatic stop_test();
		if (miscompares == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		comparisons++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// one-cycle write strobe, released at the edge that takes it
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe is taken
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		rd_val = reg_rdata;
		chk(rd_val, exp, "read");
	endtask

	// key then target write, well inside the four-cycle window
	task automatic pw(input logic [7:0] a, input logic [7:0] d);
		wr(PROTECT_KEY_OFFSET, PROTECT_KEY_VALUE);
		wr(a, d);
	endtask

	task automatic wait1();
		@(posedge mclk);
		#1;
	endtask

	// reset moves only on a rising edge, held for six edges at start-up
	task automatic apply_reset();
		@(posedge mclk);
		reset <= 1'b1;
		repeat (5) @(posedge mclk);
		reset <= 1'b0;
	endtask

	// a block with clk_en low must not take a write
	task automatic test_clock_enable();
		@(posedge mclk);
		clk_en <= 1'b0;
		wr(RTC_CLOCK_SELECT_OFFSET, 8'h03);
		@(posedge mclk);
		clk_en <= 1'b1;
		rd_chk(RTC_CLOCK_SELECT_OFFSET, 8'h0F); // write lost
	endtask

	task automatic test_reset_values();
		rd_chk(OSCILLATOR_ENABLES_OFFSET, 8'h01);
		chk(8'(osc_enable), 8'h01, "enables");
		rd_chk(CLOCK_CONFIG_FREEZE_OFFSET, 8'h00);
		rd_chk(PRESCALER_REGISTER_OFFSET, 8'h00);
	endtask

	task automatic test_protection();
		wr(PRESCALER_REGISTER_OFFSET, 8'h03);
		rd_chk(PRESCALER_REGISTER_OFFSET, 8'h00);
		wr(PROTECT_KEY_OFFSET, PROTECT_KEY_VALUE);
		repeat (6) @(posedge mclk);
		wr(PRESCALER_REGISTER_OFFSET, 8'h03);
		rd_chk(PRESCALER_REGISTER_OFFSET, 8'h00);
		pw(PRESCALER_REGISTER_OFFSET, 8'h03);
		rd_chk(PRESCALER_REGISTER_OFFSET, 8'h03);
		wr(CLOCK_CONFIG_FREEZE_OFFSET, 8'h01);
		rd_chk(CLOCK_CONFIG_FREEZE_OFFSET, 8'h00);
		pw(PRESCALER_REGISTER_OFFSET, 8'hFF);
		rd_chk(PRESCALER_REGISTER_OFFSET, 8'h7F);
		chk(8'(prescale_a_select), 8'h1F, "prescale a");
	endtask

	// per-code dividers of stage b and c, counted over 32 quad ticks
	task automatic test_prescaler();
		int div_b [4] = '{1, 1, 4, 2};
		int div_c [4] = '{1, 2, 1, 2};
		int nd;
		int nc;
		for (int c = 0; c < 4; c++)
		begin
			pw(PRESCALER_REGISTER_OFFSET, 8'(c));
			repeat (8) @(posedge mclk);
			nd = 0;
			nc = 0;
			repeat (64)
			begin
				wait1();
				nd += int'(double_rate_tick);
				nc += int'(cpu_tick);
			end
			chk(8'(nd), 8'(32 / div_b[c]), "double rate");
			chk(8'(nc), 8'(32 / (div_b[c] * div_c[c])), "cpu");
		end
	endtask

	task automatic test_rtc();
		logic [7:0] exp;
		for (int s = 0; s < 8; s++)
		begin
			wr(RTC_CLOCK_SELECT_OFFSET, 8'({s[2:0], 1'b1}));
			wait1();
			exp = (s == 0) ? 8'h08 : (s == 1) ? 8'h04 :
				(s == 2) ? 8'h02 : (s == 5) ? 8'h01 : 8'h00;
			chk(8'(rtc_route), exp, "rtc route");
		end
		wr(RTC_CLOCK_SELECT_OFFSET, 8'h0A);
		wait1();
		chk(8'(rtc_route), 8'h00, "rtc gated");
		wr(RTC_CLOCK_SELECT_OFFSET, 8'hFF);
		rd_chk(RTC_CLOCK_SELECT_OFFSET, 8'h0F);
	endtask

	task automatic test_crystal();
		for (int r = 0; r < 4; r++)
		begin
			wr(CRYSTAL_OSC_CONFIG_OFFSET, 8'({r[1:0], 6'h00}));
			wait1();
			chk(8'(crystal_setting.crystal_range_select), 8'(r), "range");
		end
		wr(CRYSTAL_OSC_CONFIG_OFFSET, 8'hFF);
		rd_chk(CRYSTAL_OSC_CONFIG_OFFSET, 8'hEF);
		chk(8'(crystal_setting), 8'h7F, "crystal");
	endtask

	task automatic test_osc();
		for (int i = 0; i < 5; i++)
		begin
			wr(OSCILLATOR_ENABLES_OFFSET, 8'(1 << i));
			wait1();
			chk(8'(osc_enable), 8'(1 << i), "enable bit");
		end
		wr(OSCILLATOR_ENABLES_OFFSET, 8'hFF);
		rd_chk(OSCILLATOR_READY_FLAGS_OFFSET, 8'h00);
		repeat (50) @(posedge mclk);
		rd_chk(OSCILLATOR_READY_FLAGS_OFFSET, 8'h1F);
		rd_chk(OSCILLATOR_ENABLES_OFFSET, 8'h1F);
		wr(OSCILLATOR_READY_FLAGS_OFFSET, 8'h00);
		rd_chk(OSCILLATOR_READY_FLAGS_OFFSET, 8'h1F);
		pw(SYS_CLOCK_SELECT_OFFSET, 8'h03); // external is stable
		rd_chk(SYS_CLOCK_SELECT_OFFSET, 8'h03);
		pw(SYS_CLOCK_SELECT_OFFSET, 8'h01); // fast source is ready
		rd_chk(SYS_CLOCK_SELECT_OFFSET, 8'h01);
		wr(OSCILLATOR_ENABLES_OFFSET, 8'h03);
		rd_chk(OSCILLATOR_READY_FLAGS_OFFSET, 8'h03);
		wr(OSCILLATOR_ENABLES_OFFSET, 8'h13); // pll set up first
		rd_chk(OSCILLATOR_READY_FLAGS_OFFSET, 8'h03);
		repeat (40) @(posedge mclk);
		rd_chk(OSCILLATOR_READY_FLAGS_OFFSET, 8'h13);
	endtask

	task automatic test_lock();
		pw(PRESCALER_REGISTER_OFFSET, 8'h02);
		pw(CLOCK_CONFIG_FREEZE_OFFSET, 8'h01);
		wait1();
		chk(8'(clock_config_frozen), 8'h01, "frozen");
		pw(PRESCALER_REGISTER_OFFSET, 8'h01);
		rd_chk(PRESCALER_REGISTER_OFFSET, 8'h02);
		pw(SYS_CLOCK_SELECT_OFFSET, 8'h00);
		rd_chk(SYS_CLOCK_SELECT_OFFSET, 8'h01);
		chk(8'(sys_clock_select), 8'h01, "sys select");
		pw(CLOCK_CONFIG_FREEZE_OFFSET, 8'h00);
		rd_chk(CLOCK_CONFIG_FREEZE_OFFSET, 8'h01);
		apply_reset();
		rd_chk(CLOCK_CONFIG_FREEZE_OFFSET, 8'h00);
		rd_chk(OSCILLATOR_ENABLES_OFFSET, 8'h01);
		pw(PRESCALER_REGISTER_OFFSET, 8'h01);
		rd_chk(PRESCALER_REGISTER_OFFSET, 8'h01);
	endtask

	// main sequence
	initial
	begin
		mclk = 1'b0;
		reset = 1'b1;
		clk_en = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		miscompares = 0;
		comparisons = 0;
		cycles = 0;
		apply_reset();
		test_reset_values();
		test_protection();
		test_prescaler();
		test_rtc();
		test_clock_enable();
		test_crystal();
		test_osc();
		test_lock();
		stop_test();
	end
endmodule
